// ===== hdl/eabd_top.v
`timescale 1ns/1ps
`include "eabd_consts.vh"

module eabd_top (
	// clock and reset
	input wire clk_in,
	input wire reset_in,
	// serial link from host (mode 0)
	input wire sck_in,
	input wire cs_n_in,
	input wire mosi_in,
	output reg miso_out,
	output reg miso_oe_out,
	// sector option strap reported in status register 2
	input wire uniform_sector_option_flag_in,
	// decoded array address for read instructions
	output reg [31:0] array_addr_out,
	output reg array_addr_valid_out,
	// bank register contents
	output reg [7:0] extended_address_bank_out
);

	localparam [2:0] ST_CMD = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_DUMMY = 3'h2;
	localparam [2:0] ST_DATA = 3'h3;
	localparam [2:0] ST_WDATA = 3'h4;
	localparam [2:0] ST_IGNORE = 3'h5;

	wire sck_sync;
	wire cs_n_sync;
	wire mosi_sync;
	wire opt_sync;

	eabd_sync #(.RESET_VAL(1'b0)) u_sync_sck (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.d_in(sck_in),
		.q_out(sck_sync)
	);
	eabd_sync #(.RESET_VAL(1'b1)) u_sync_cs (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.d_in(cs_n_in),
		.q_out(cs_n_sync)
	);
	eabd_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.d_in(mosi_in),
		.q_out(mosi_sync)
	);
	eabd_sync #(.RESET_VAL(1'b0)) u_sync_opt (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.d_in(uniform_sector_option_flag_in),
		.q_out(opt_sync)
	);

	reg sck_prev_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] bit_cnt_reg;
	reg [2:0] byte_cnt_reg;
	reg [2:0] byte_cnt_next;
	reg [2:0] addr_len_reg;
	reg [2:0] addr_len_next;
	reg [7:0] rx_reg;
	reg [7:0] cmd_reg;
	reg [7:0] cmd_next;
	reg [31:0] addr_reg;
	reg [31:0] addr_next;
	reg [7:0] tx_reg;
	reg [7:0] tx_next;
	reg [7:0] bank_next;
	reg [31:0] out_addr_next;
	reg out_valid_next;

	wire sck_rise = sck_sync & ~sck_prev_reg;
	wire sck_fall = ~sck_sync & sck_prev_reg;
	wire [7:0] rx_byte = {rx_reg[6:0], mosi_sync};
	wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);
	wire four_byte_mode = extended_address_bank_out[`EABD_BANK_MODE_BIT];
	wire [7:0] stat2_value = {opt_sync, 7'h00};

	// discovery table lookup; unused locations read as erased bytes
	function [7:0] disc_byte;
		input [31:0] ofs;
		reg [31:0] word;
		begin
			word = 32'hFFFFFFFF;
			if (ofs[31:8] == 24'h000000) begin
				if (ofs[7:2] == `EABD_DISC_WIDX_BFP16)
					word = `EABD_DISC_WORD_BFP16;
				else if (ofs[7:2] == `EABD_DISC_WIDX_DET1)
					word = `EABD_DISC_WORD_DET1;
			end
			case (ofs[1:0])
				2'h0: disc_byte = word[7:0];
				2'h1: disc_byte = word[15:8];
				2'h2: disc_byte = word[23:16];
				default: disc_byte = word[31:24];
			endcase
		end
	endfunction

	// per-byte decisions, taken on the eighth rising clock edge of a byte
	always @* begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		addr_next = addr_reg;
		byte_cnt_next = byte_cnt_reg;
		addr_len_next = addr_len_reg;
		tx_next = tx_reg;
		bank_next = extended_address_bank_out;
		out_addr_next = array_addr_out;
		out_valid_next = 1'b0;
		if (byte_done) begin
			case (state_reg)
				ST_CMD: begin
					cmd_next = rx_byte;
					byte_cnt_next = 3'h0;
					addr_next = 32'h00000000;
					case (rx_byte)
						`EABD_CMD_RD_BANK: begin
							tx_next = extended_address_bank_out;
							state_next = ST_DATA;
						end
						`EABD_CMD_RD_STAT2: begin
							tx_next = stat2_value;
							state_next = ST_DATA;
						end
						`EABD_CMD_WR_BANK: state_next = ST_WDATA;
						`EABD_CMD_SOFT_RST: begin
							bank_next = `EABD_BANK_RESET;
							state_next = ST_IGNORE;
						end
						`EABD_CMD_RD_DISC: begin
							addr_len_next = `EABD_ADDR_BYTES_3;
							state_next = ST_ADDR;
						end
						`EABD_CMD_READ3: begin
							// legacy read follows the bank mode bit
							addr_len_next = four_byte_mode ? `EABD_ADDR_BYTES_4 :
								`EABD_ADDR_BYTES_3;
							state_next = ST_ADDR;
						end
						`EABD_CMD_READ4: begin
							addr_len_next = `EABD_ADDR_BYTES_4;
							state_next = ST_ADDR;
						end
						default: state_next = ST_IGNORE;
					endcase
				end
				ST_ADDR: begin
					addr_next = {addr_reg[23:0], rx_byte};
					byte_cnt_next = byte_cnt_reg + 3'h1;
					if (byte_cnt_next == addr_len_reg) begin
						if (cmd_reg == `EABD_CMD_RD_DISC) begin
							state_next = ST_DUMMY;
						end else begin
							if (addr_len_reg == `EABD_ADDR_BYTES_4)
								out_addr_next = addr_next;
							else
								out_addr_next = {1'b0,
									extended_address_bank_out[6:0],
									addr_next[23:0]};
							out_valid_next = 1'b1;
							// array access lies outside this block
							state_next = ST_IGNORE;
						end
					end
				end
				ST_DUMMY: begin
					tx_next = disc_byte(addr_reg);
					state_next = ST_DATA;
				end
				ST_DATA: begin
					if (cmd_reg == `EABD_CMD_RD_DISC) begin
						addr_next = addr_reg + 32'h00000001;
						tx_next = disc_byte(addr_next);
					end else if (cmd_reg == `EABD_CMD_RD_BANK) begin
						tx_next = extended_address_bank_out;
					end else begin
						tx_next = stat2_value;
					end
				end
				ST_WDATA: begin
					bank_next = rx_byte;
					// further bytes are ignored so only one byte is taken
					state_next = ST_IGNORE;
				end
				default: state_next = ST_IGNORE;
			endcase
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			sck_prev_reg <= 1'b0;
			state_reg <= ST_CMD;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			addr_len_reg <= `EABD_ADDR_BYTES_3;
			rx_reg <= 8'h00;
			cmd_reg <= 8'h00;
			addr_reg <= 32'h00000000;
			tx_reg <= 8'h00;
			extended_address_bank_out <= `EABD_BANK_RESET;
			array_addr_out <= 32'h00000000;
			array_addr_valid_out <= 1'b0;
			miso_out <= 1'b0;
			miso_oe_out <= 1'b0;
		end else begin
			sck_prev_reg <= sck_sync;
			array_addr_valid_out <= out_valid_next;
			extended_address_bank_out <= bank_next;
			array_addr_out <= out_addr_next;
			if (cs_n_sync) begin
				// deselect aborts any frame; a partial byte is dropped
				state_reg <= ST_CMD;
				bit_cnt_reg <= 3'h0;
				miso_oe_out <= 1'b0;
				miso_out <= 1'b0;
			end else begin
				state_reg <= state_next;
				cmd_reg <= cmd_next;
				addr_reg <= addr_next;
				byte_cnt_reg <= byte_cnt_next;
				addr_len_reg <= addr_len_next;
				if (sck_rise) begin
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					rx_reg <= rx_byte;
					if (byte_done)
						tx_reg <= tx_next;
				end
				// output changes on the falling edge, so it is stable at the rise
				if (sck_fall && state_reg == ST_DATA) begin
					miso_out <= tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
					miso_oe_out <= 1'b1;
				end
			end
		end
	end

endmodule

// ===== hdl/eabd_consts.vh
`ifndef EABD_CONSTS_VH
`define EABD_CONSTS_VH

// serial instruction codes
`define EABD_CMD_RD_BANK 8'h16
`define EABD_CMD_WR_BANK 8'h17
`define EABD_CMD_SOFT_RST 8'hF0
`define EABD_CMD_RD_STAT2 8'h07
`define EABD_CMD_RD_DISC 8'h5A
`define EABD_CMD_READ3 8'h03
`define EABD_CMD_READ4 8'h13

// bank register fields and reset value
`define EABD_BANK_RESET 8'h00
`define EABD_BANK_MODE_BIT 7

// status register 2 field carrying the sector option flag
`define EABD_STAT2_OPT_BIT 7

// discovery table: word indices (byte offset / 4) and contents
`define EABD_DISC_WIDX_BFP16 6'h0F
`define EABD_DISC_WORD_BFP16 32'hA8FA28F0
`define EABD_DISC_WIDX_DET1 6'h10
`define EABD_DISC_WORD_DET1 32'h803007FC
`define EABD_DISC_BLANK 8'hFF

// frame sizes
`define EABD_ADDR_BYTES_3 3'h3
`define EABD_ADDR_BYTES_4 3'h4

`endif

// ===== hdl/eabd_sync.v
`timescale 1ns/1ps

// two-stage synchroniser for one pin; the first stage feeds only the second
module eabd_sync #(
	parameter [0:0] RESET_VAL = 1'b0
) (
	// clock and reset
	input wire clk_in,
	input wire reset_in,
	// pin and synchronised level
	input wire d_in,
	output reg q_out
);

	reg meta_reg;

	always @(posedge clk_in) begin
		if (reset_in) begin
			meta_reg <= RESET_VAL;
			q_out <= RESET_VAL;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end

endmodule

// ===== test/eabd_host_model.sv
`timescale 1ns/1ps
// mode 0 host; sck idles low and never enters continuous mode
module eabd_host_model (
	// clock
	input wire clk_in,
	// device data
	input wire miso_in,
	input wire miso_oe_in,
	// link out
	output logic sck_out,
	output logic cs_n_out,
	output logic mosi_out
);
	initial begin
		sck_out = 0;
		cs_n_out = 1;
		mosi_out = 1;
	end
	// released mosi shows the inverse so stale bits are never mistaken for data
	// the long gap gives the idle-bus checks a quiet stretch to look at
	task sel(input logic on);
		repeat (8) @(negedge clk_in);
		cs_n_out = !on;
		mosi_out = ~mosi_out;
	endtask
	// one byte, msb first; miso taken at sck rise
	task xb(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi_out = t[i];
			repeat (20) @(negedge clk_in);
			sck_out = 1;
			r[i] = miso_oe_in ? miso_in : 1'bx;
			repeat (20) @(negedge clk_in);
			sck_out = 0;
		end
	endtask
endmodule

// ===== test/eabd_assertions.sv
`timescale 1ns/1ps
module eabd_assertions (
	// clock and reset
	input wire clk_in,
	input wire reset_in,
	// link
	input wire sck_in,
	input wire cs_n_in,
	input wire miso_out,
	input wire miso_oe_out,
	// decode and bank
	input wire [31:0] array_addr_out,
	input wire array_addr_valid_out,
	input wire [7:0] extended_address_bank_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_reset_bank_clear: assert property (disable iff (1'b0) reset_in |=>
		extended_address_bank_out == 8'h00 && !miso_oe_out) else $error("reset state wrong");
	a_oe_idle: assert property (cs_n_in [*5] |-> !miso_oe_out)
		else $error("miso driven while idle");
	a_miso_quiet: assert property (!miso_oe_out |-> !miso_out)
		else $error("miso high while undriven");
	a_miso_edge: assert property ($changed(miso_out) |-> !sck_in)
		else $error("miso moved while sck high");
	a_pulse_once: assert property (array_addr_valid_out |=> !array_addr_valid_out)
		else $error("valid longer than a cycle");
	a_addr_hold: assert property ($changed(array_addr_out) |-> array_addr_valid_out)
		else $error("address moved without valid");
	a_bank_frame: assert property ($changed(extended_address_bank_out) |->
		!$past(cs_n_in, 4)) else $error("bank moved outside frame");
	a_bank_idle: assert property (cs_n_in [*6] |=>
		$stable(extended_address_bank_out)) else $error("bank moved while idle");
	a_valid_frame: assert property (array_addr_valid_out |-> !$past(cs_n_in, 3))
		else $error("valid outside frame");
endmodule
bind eabd_top eabd_assertions chk_i (.clk_in, .reset_in, .sck_in, .cs_n_in, .miso_out,
	.miso_oe_out, .array_addr_out, .array_addr_valid_out, .extended_address_bank_out);

// ===== test/tb_extended_address_bank_and_discovery.sv
`timescale 1ns/1ps
module tb_extended_address_bank_and_discovery;
	logic clk_in = 0;
	logic reset_in = 1;
	logic flag = 0;
	wire sck, cs_n, mosi, miso, miso_oe, valid;
	wire [31:0] addr;
	wire [7:0] bank;
	logic [31:0] got_addr = 0;
	logic [7:0] rx [10];
	int mismatches = 0;
	int comparisons = 0;
	always #2 clk_in = ~clk_in;
	eabd_top dut (.clk_in(clk_in), .reset_in(reset_in), .sck_in(sck), .cs_n_in(cs_n),
		.mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
		.uniform_sector_option_flag_in(flag), .array_addr_out(addr),
		.array_addr_valid_out(valid), .extended_address_bank_out(bank));
	eabd_host_model host (.clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
		.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));
	// the pulse is gone before the frame ends, so latch it
	always @(posedge clk_in) if (valid === 1'b1) got_addr <= addr;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	// bytes go out from the low end of t upwards
	task fr(input logic [79:0] t, input int n);
		host.sel(1);
		for (int i = 0; i < n; i++) host.xb(t[8*i +: 8], rx[i]);
		host.sel(0);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		reset_in = 0;
		fr(80'h16, 2);
		chk("bank read", 8'h00, rx[1]);
		fr(80'h85_17, 2);
		chk("bank out", 8'h85, bank);
		fr(80'h16, 3);
		chk("bank reread", 8'h85, rx[2]);
		fr(80'h78_56_34_12_03, 5);
		chk("addr four", 32'h12345678, got_addr);
		// trailing byte after the data byte must be dropped
		fr(80'hAA_05_17, 3);
		fr(80'hEF_CD_AB_03, 4);
		chk("addr three", 32'h05ABCDEF, got_addr);
		fr(80'hF0_DE_BC_9A_13, 5);
		chk("addr dedicated", 32'h9ABCDEF0, got_addr);
		fr(80'hF0, 1);
		chk("bank soft reset", 8'h00, bank);
		for (int f = 0; f < 2; f++) begin
			flag = f[0];
			fr(80'h07, 2);
			chk("status opt", {f[0], 7'h00}, rx[1] & 8'h80);
		end
		fr(80'h40_00_00_5A, 10);
		chk("detect word", 32'h803007FC, {rx[8], rx[7], rx[6], rx[5]});
		chk("detect flags", 2'b00, rx[5][1:0]);
		chk("past table", 8'hFF, rx[9]);
		// a reset in mid-run must also bring the bank back to its default
		fr(80'hC3_17, 2);
		chk("bank before reset", 8'hC3, bank);
		reset_in = 1;
		repeat (4) @(negedge clk_in);
		reset_in = 0;
		chk("bank after reset", 8'h00, bank);
		fr(80'h16, 2);
		chk("bank read after reset", 8'h00, rx[1]);
		give_verdict();
	end
endmodule
